// ==== rtl/anp_next_page_tx.sv ====
`timescale 1ns/1ps
`default_nettype none

module anp_next_page_tx (
  // Clock and reset
  input  wire logic                       sys_clk_in,
  input  wire logic                       sys_rst_in,
  // Management access from the station
  input  wire anp_pkg::anp_mgmt_req_type  mgmt_req_in,
  output logic [15:0]                     mgmt_rdata_out,
  // Negotiation engine side
  input  wire logic                       base_toggle_in,
  input  wire logic                       first_page_in,
  input  wire logic                       page_sent_in,
  input  wire logic                       partner_page_valid_in,
  input  wire logic [15:0]                partner_page_in,
  // Word to transmit
  output anp_pkg::anp_word_type           tx_word_out
);

  // Writable fields of the transmit register; they double as the fields
  // of the outgoing word, so the transmitter keeps no copy of its own
  logic        more_q;          // Next page request
  logic        msg_q;           // Message page select
  logic        ack_two_flag_q;          // Compliance indication
  logic [10:0] code_q;          // Message or unformatted code

  // State that the device keeps for itself
  logic        toggle_q;        // Toggle of the word now on offer
  logic [15:0] partner_q;       // Last received partner page
  logic [15:0] rdata_q;         // Registered read data

  // Address decode; only the two next page addresses live in this block,
  // and every other address reads back the unmapped pattern
  wire         hit_tx      = (mgmt_req_in.addr == anp_pkg::NP_TX_ADDR);
  wire         hit_partner = (mgmt_req_in.addr == anp_pkg::PARTNER_NP_ADDR);
  wire         hit_none    = !hit_tx && !hit_partner;       // Unmapped address

  // Write strobe for the transmit register; a write to any other address,
  // the read-only partner register included, is dropped without trace
  wire         wr_tx       = mgmt_req_in.wr && hit_tx;
  wire         wr_partner  = mgmt_req_in.wr && hit_partner;  // Ignored write

  // Read strobes per target; they feed only the checks further down
  wire         rd_tx       = mgmt_req_in.rd && hit_tx;
  wire         rd_partner  = mgmt_req_in.rd && hit_partner;
  wire         rd_none     = mgmt_req_in.rd && hit_none;

  // Next toggle: the first next page inverts bit 11 of the base word, and
  // every later page inverts the toggle of the page sent just before it
  wire         toggle_d    = first_page_in ? ~base_toggle_in : ~toggle_q;

  // Read view of the transmit register; the reserved bit is a constant,
  // so a stray one from a careless station can never read back
  wire [15:0]  tx_view     = {more_q, anp_pkg::RESERVED_VAL, msg_q, ack_two_flag_q,
                              toggle_q, code_q};

  // Read data select; the partner register is returned as captured
  wire [15:0]  rdata_d     = hit_tx      ? tx_view :
                             hit_partner ? partner_q :
                                           anp_pkg::UNMAPPED_DATA;

  // Writable fields; the toggle and reserved bits of a write are dropped,
  // which keeps the toggle in step with the link whatever the station does
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      // Power-up values: last page, message page, code one
      more_q <= anp_pkg::MORE_PAGES_RST;
      msg_q  <= anp_pkg::MSG_PAGE_RST;
      ack_two_flag_q <= anp_pkg::ACK_TWO_RST;
      code_q <= anp_pkg::CODE_RST;
    end else if (wr_tx) begin
      // Field-by-field copy of the written word
      more_q <= mgmt_req_in.wdata[anp_pkg::MORE_PAGES_BIT];
      msg_q  <= mgmt_req_in.wdata[anp_pkg::MSG_PAGE_BIT];
      ack_two_flag_q <= mgmt_req_in.wdata[anp_pkg::ACK_TWO_BIT];
      code_q <= mgmt_req_in.wdata[anp_pkg::CODE_MSB:0];
    end
  end

  // Toggle advances only when a page goes out, never on a write; a
  // station that needs the current value simply reads it back
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      toggle_q <= anp_pkg::TOGGLE_RST;
    end else if (page_sent_in) begin
      // The word has left; the next one carries the inverted toggle
      toggle_q <= toggle_d;
    end
  end

  // Partner page capture; the engine pulses valid once per received page,
  // and the register keeps that page until the next pulse
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      partner_q <= anp_pkg::DATA_RST;
    end else if (partner_page_valid_in) begin
      partner_q <= partner_page_in;
    end
  end

  // Read data is sampled on the read strobe and then held, so the station
  // may collect it late; a write in the same cycle is not yet visible
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rdata_q <= anp_pkg::DATA_RST;
    end else if (mgmt_req_in.rd) begin
      rdata_q <= rdata_d;
    end
  end

  // Read data leaves straight from its flip-flops
  assign mgmt_rdata_out = rdata_q;

  // Outgoing word mirrors the register fields; no stage is added, so a
  // write shows on the link side in the cycle after it is taken
  always_comb begin
    tx_word_out.more_pages_flag   = more_q;
    tx_word_out.reserved          = anp_pkg::RESERVED_VAL;
    tx_word_out.message_page_flag = msg_q;
    tx_word_out.ack_two_flag      = ack_two_flag_q;
    tx_word_out.toggle            = toggle_q;
    tx_word_out.code              = code_q;
  end

  // Checks below share the one clock and sleep through reset; each is
  // stated from the rule it guards, not from the expressions above

  // Reads of the transmit register never show the reserved bit set,
  // whatever the station may have put into that position
  reserved_zero_a : assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    rd_tx |=> mgmt_rdata_out[anp_pkg::RESERVED_BIT] == anp_pkg::RESERVED_VAL)
    else $error("reserved bit read nonzero");

  // Each page sent after the first flips the toggle of the word on offer,
  // so the partner can tell a new page from a repeat
  toggle_flip_a : assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    page_sent_in && !first_page_in |=> tx_word_out.toggle != $past(tx_word_out.toggle))
    else $error("toggle did not invert");

  // The first next page takes the inverse of the base word toggle,
  // regardless of what the toggle held before
  first_toggle_a : assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    page_sent_in && first_page_in |=> tx_word_out.toggle == !$past(base_toggle_in))
    else $error("first toggle wrong");

  // Without a sent page the toggle holds; station writes to the
  // transmit register cannot move it
  toggle_ro_a : assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !page_sent_in |=> $stable(tx_word_out.toggle))
    else $error("toggle changed without page");

  // A written message page flag reaches the outgoing word one cycle
  // after the write is taken
  msg_page_a : assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    wr_tx |=>
    tx_word_out.message_page_flag == $past(mgmt_req_in.wdata[anp_pkg::MSG_PAGE_BIT]))
    else $error("message page flag mismatch");

  // A written compliance flag reaches the outgoing word one cycle
  // after the write is taken
  ack_two_a : assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    wr_tx |=>
    tx_word_out.ack_two_flag == $past(mgmt_req_in.wdata[anp_pkg::ACK_TWO_BIT]))
    else $error("ack two flag mismatch");

  // The written code field goes out bit for bit, one cycle after the
  // write is taken
  code_copy_a : assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    wr_tx |=>
    tx_word_out.code == $past(mgmt_req_in.wdata[anp_pkg::CODE_MSB:0]))
    else $error("code field mismatch");

  // A written more pages flag reaches the outgoing word one cycle
  // after the write is taken
  more_pages_a : assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    wr_tx |=>
    tx_word_out.more_pages_flag == $past(mgmt_req_in.wdata[anp_pkg::MORE_PAGES_BIT]))
    else $error("more pages flag mismatch");

  // Partner register reads return the captured page; a capture in the
  // same cycle is left out, as the read then sees the older page
  partner_read_a : assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    rd_partner && !partner_page_valid_in |=> mgmt_rdata_out == partner_q)
    else $error("partner register read wrong");

  // A captured partner page is kept exactly as the engine handed it
  // over, with no bit altered on the way in
  partner_capture_a : assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    partner_page_valid_in |=> partner_q == $past(partner_page_in))
    else $error("partner page not captured");

  // The partner register is read-only: a station write to it changes
  // nothing unless the engine captures a page in the same cycle
  partner_write_a : assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    wr_partner && !partner_page_valid_in |=> $stable(partner_q))
    else $error("partner register took a write");

  // A read of the transmit register returns the word on offer at the
  // read, toggle included, so the station sees what the link sees
  tx_read_a : assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    rd_tx |=> mgmt_rdata_out == $past(tx_word_out))
    else $error("transmit register read wrong");

  // Reads of any unmapped address return the fixed pattern, never
  // a leftover of an earlier answer
  unmapped_read_a : assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    rd_none |=> mgmt_rdata_out == anp_pkg::UNMAPPED_DATA)
    else $error("unmapped read not fixed pattern");

  // Writes to other addresses leave the outgoing word untouched, so
  // only the transmit register can change what goes out
  write_ignored_a : assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    mgmt_req_in.wr && !hit_tx && !page_sent_in |=> $stable(tx_word_out))
    else $error("word changed by foreign write");

endmodule : anp_next_page_tx

`default_nettype wire

// ==== rtl/anp_pkg.sv ====
package anp_pkg;

  // Register addresses on the management port
  localparam logic [4:0]  NP_TX_ADDR        = 5'h07;
  localparam logic [4:0]  PARTNER_NP_ADDR   = 5'h08;

  // Field positions of the next page transmit register
  localparam int          MORE_PAGES_BIT    = 15;
  localparam int          RESERVED_BIT      = 14;
  localparam int          MSG_PAGE_BIT      = 13;
  localparam int          ACK_TWO_BIT       = 12;
  localparam int          TOGGLE_BIT        = 11;
  localparam int          CODE_MSB          = 10;

  // Reset values of the writable fields
  localparam logic        MORE_PAGES_RST    = 1'h0;
  localparam logic        MSG_PAGE_RST      = 1'h1;
  localparam logic        ACK_TWO_RST       = 1'h0;
  localparam logic [10:0] CODE_RST          = 11'h001;

  // Value returned for an unmapped address
  localparam logic [15:0] UNMAPPED_DATA     = 16'h0000;

  // Reset value of the device-kept toggle
  localparam logic        TOGGLE_RST        = 1'h0;

  // Level of the reserved bit, in the read view and on the link alike
  localparam logic        RESERVED_VAL      = 1'h0;

  // Reset value of the partner register and of the read data
  localparam logic [15:0] DATA_RST          = 16'h0000;

  // Next page link control word as sent to the remote partner
  typedef struct packed {
    logic        more_pages_flag;
    logic        reserved;
    logic        message_page_flag;
    logic        ack_two_flag;
    logic        toggle;
    logic [10:0] code;
  } anp_word_type;

  // Management register access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } anp_mgmt_req_type;

endpackage : anp_pkg

// ==== verification/anp_next_page_tx_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module anp_next_page_tx_tb;
  // Clock, reset and block signals
  logic                      clk, rst, base_t, first_p, sent, pv;
  logic [15:0]               pdata, rdata, got;
  anp_pkg::anp_mgmt_req_type req;
  anp_pkg::anp_word_type     tx;
  int                        bad_count = 0;
  int                        n_checks = 0;
  // 40 MHz clock
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  anp_next_page_tx u_dut (.sys_clk_in(clk), .sys_rst_in(rst), .mgmt_req_in(req),
    .mgmt_rdata_out(rdata), .base_toggle_in(base_t), .first_page_in(first_p),
    .page_sent_in(sent), .partner_page_valid_in(pv), .partner_page_in(pdata),
    .tx_word_out(tx));
  anp_sta_model u_sta (.sys_clk_in(clk), .rdata_in(rdata), .req_out(req));
  // Compare and count
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Read through the station and compare
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    u_sta.get(a, got);
    chk("read data", e, got);
  endtask : rd_chk
  // Pulse a sent page, then check the word now offered
  task automatic pg(input logic f, input logic b, input logic [15:0] e);
    @(negedge clk);
    first_p = f;
    base_t = b;
    sent = 1'h1;
    @(negedge clk);
    sent = 1'h0;
    first_p = 1'h0;
    chk("tx word", e, tx);
  endtask : pg
  // Single exit point of the run
  task automatic give_verdict();
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // Main sequence
  initial begin
    rst = 1'h1;
    {base_t, first_p, sent, pv} = 4'h0;
    pdata = 16'h0000;
    repeat (8) @(negedge clk);
    rst = 1'h0;
    chk("tx word", 16'h2001, tx);
    rd_chk(5'h07, 16'h2001);
    rd_chk(5'h08, 16'h0000);
    u_sta.put(5'h07, 16'hB805);
    chk("tx word", 16'hB005, tx);
    rd_chk(5'h07, 16'hB005);
    u_sta.put(5'h07, 16'h17FA);
    chk("tx word", 16'h17FA, tx);
    u_sta.put(5'h07, 16'h2155);
    chk("tx word", 16'h2155, tx);
    pg(1'h1, 1'h0, 16'h2955);
    pg(1'h0, 1'h0, 16'h2155);
    pg(1'h0, 1'h1, 16'h2955);
    pg(1'h1, 1'h1, 16'h2155);
    pg(1'h1, 1'h0, 16'h2955);
    rd_chk(5'h07, 16'h2955);
    u_sta.put(5'h07, 16'h0000);
    chk("tx word", 16'h0800, tx);
    // Partner page capture; the word is scrambled once the pulse is over
    @(negedge clk);
    pdata = 16'hA5C3;
    pv = 1'h1;
    @(negedge clk);
    pv = 1'h0;
    pdata = ~pdata;
    rd_chk(5'h08, 16'hA5C3);
    u_sta.put(5'h08, 16'h1234);
    rd_chk(5'h08, 16'hA5C3);
    rd_chk(5'h1F, 16'h0000);
    // Mid-run reset brings back the defaults, toggle and partner page too
    @(negedge clk);
    rst = 1'h1;
    repeat (2) @(negedge clk);
    rst = 1'h0;
    chk("tx word", 16'h2001, tx);
    rd_chk(5'h07, 16'h2001);
    rd_chk(5'h08, 16'h0000);
    give_verdict();
  end
endmodule : anp_next_page_tx_tb
`default_nettype wire

// ==== verification/anp_sta_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module anp_sta_model (
  // Clock and returned read data
  input  wire logic                  sys_clk_in,
  input  wire logic [15:0]           rdata_in,
  // Requests to the block
  output anp_pkg::anp_mgmt_req_type  req_out
);
  // Idle until a task drives a request
  initial req_out = '0;
  // One-cycle write; bit 14 always carries its default of zero
  task automatic put(input logic [4:0] a, input logic [15:0] d);
    @(negedge sys_clk_in);
    req_out = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: {d[15], 1'h0, d[13:0]}};
    @(negedge sys_clk_in);
    // Released bus shows the inverse of what it carried, never stale data
    req_out = '{wr: 1'h0, rd: 1'h0, addr: ~req_out.addr, wdata: ~req_out.wdata};
  endtask : put
  // One-cycle read; data taken once the answering edge has landed
  task automatic get(input logic [4:0] a, output logic [15:0] d);
    @(negedge sys_clk_in);
    req_out = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 16'hFFFF};
    @(negedge sys_clk_in);
    d = rdata_in;
    req_out = '{wr: 1'h0, rd: 1'h0, addr: ~req_out.addr, wdata: ~req_out.wdata};
  endtask : get
endmodule : anp_sta_model
`default_nettype wire
